/* File: inc/sdram_pkg.sv */
// Shared constants for the SDRAM burst, byte mask and suspend core.
// Assumes commands are sampled on the rising edge of one system clock.
package sdram_pkg;

  // Array geometry: two banks, 11 row bits, 8 column bits, 16 data bits
  localparam int ADDR_W = 12;
  localparam int ROW_W = 11;
  localparam int COL_W = 8;
  localparam int DQ_W = 16;
  localparam int BYTE_W = 8;
  localparam int MEM_AW = 20;

  // Command codes as {ras_n, cas_n, we_n} with chip select low
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_BST = 3'h6;

  // Address bit positions
  localparam int ALL_BANKS_BIT = 10;
  localparam int BANK_SELECT_BIT = 11;

  // Mode word field positions
  localparam int MR_BL_LSB = 0;
  localparam int MR_CL_LSB = 4;
  localparam int MR_SINGLE_WR_BIT = 9;

  // Burst length codes
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;

  // CAS latency codes
  localparam logic [2:0] CL_2 = 3'h2;
  localparam logic [2:0] CL_3 = 3'h3;

  // Mode reset values
  localparam logic [2:0] MR_BL_RST = 3'h0;
  localparam logic [2:0] MR_CL_RST = 3'h3;
  localparam logic MR_SINGLE_WR_RST = 1'b0;

  // Timing in clock cycles
  localparam int MASK_TO_OUTPUT_DELAY = 2;
  localparam int WRITE_STOP_DELAY = 0;

  // Pin synchroniser: {cke, cs_n, ras_n, cas_n, we_n, addr, masks, dq}
  localparam int SYNC_W = 35;
  localparam logic [34:0] SYNC_RST = 35'h7C0000000;

  // Burst engine states, Gray along idle, read, write
  typedef enum logic [1:0] {
    BS_IDLE = 2'b00,
    BS_READ = 2'b01,
    BS_WRITE = 2'b11
  } burst_state_e;

endpackage

/* File: core/byte_lane.sv */
// One data byte lane: read output register and mask-driven enable.
// Assumes mask and hold come from already synchronised logic.
`timescale 1ns/1ps
module byte_lane (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hold,
  input wire logic mask,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  output logic [7:0] dq_out,
  output logic [7:0] dq_oe_n
);

  // Mask seen one cycle ago; output register adds the second cycle
  logic mask_d1_r;

  // First stage of the fixed two-cycle mask path
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_d1_r <= 1'b0;
    end else if (!hold) begin
      mask_d1_r <= mask; // [R5] [R6]
    end
  end

  // Output data and active-low enable, frozen while suspended
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dq_out <= 8'h00;
      dq_oe_n <= 8'hFF;
    end else if (!hold) begin
      dq_out <= rd_data;
      // Masked bytes float; burst data still flows past
      dq_oe_n <= {8{~(rd_valid & ~mask_d1_r)}}; // [R5] [R6] [R8]
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Unmasking brings a live read byte back after two cycles
  property p_resume;
    (!mask && !hold) ##1 (!hold && rd_valid) |=> dq_oe_n == 8'h00;
  endproperty
  a_resume: assert property (p_resume) // [R6]
    else $error("byte lane not driven after mask release");

endmodule

/* File: core/sdram_bms_core.sv */
// Device-side SDRAM core: bursts, burst stop, byte masks, suspend.
// Assumes a controller on the same clock keeps bank timing limits.
//
// Summary of operation
// R1: Full-page write walks start..start+255, then wraps
// R2: Controller ends full-page write with burst stop
// R3: Controller precharges before activate-to-precharge maximum
// R4: Burst stop ends write data instantly
// R5: Read byte floats two cycles after mask
// R6: Byte stays floating while masked, resumes likewise
// R7: Upper mask owns high byte, lower low
// R8: Masking leaves burst and counter running
// R9: Masked write byte dropped same cycle
// R10: Write masks gate their own byte only
// R11: Single-write mode: reads burst, writes one word
// R12: Latencies unchanged in single-write mode
// R13: Controller activates only idle precharged banks
// R14: Controller spaces activates to different banks
// R15: Controller keeps activate-to-precharge within bounds
// R16: Controller waits row-to-column delay before access
// R17: Clock gate low freezes state next edge
// R18: Suspended device ignores all commands
// R19: Clock gate high resumes next edge
// R20: Controller refreshes in time despite suspend
// R21: Precharge one bank, or both with A10
// R22: Column counter is 8-bit, loaded per command
`timescale 1ns/1ps
module sdram_bms_core (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [11:0] addr,
  input wire logic upper_byte_mask,
  input wire logic lower_byte_mask,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic [15:0] dq_oe_n
);

  // Two-stage pin synchroniser
  logic [34:0] sync1_r;
  logic [34:0] sync2_r;
  // Synchronised pin views
  logic cke_s;
  logic cs_n_s;
  logic ras_n_s;
  logic cas_n_s;
  logic we_n_s;
  logic [11:0] addr_s;
  logic um_s;
  logic lm_s;
  logic [15:0] dq_s;

  // Every pin goes through two flops; only the second is read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_r <= sdram_pkg::SYNC_RST;
      sync2_r <= sdram_pkg::SYNC_RST;
    end else begin
      sync1_r <= {cke, cs_n, ras_n, cas_n, we_n, addr,
                  upper_byte_mask, lower_byte_mask, dq_in};
      sync2_r <= sync1_r;
    end
  end

  assign {cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, addr_s,
          um_s, lm_s, dq_s} = sync2_r;

  // Suspend: all but the pin synchroniser freezes while the clock gate is low
  logic hold;
  assign hold = ~cke_s; // [R17] [R19]

  // Command decode, blocked entirely during suspend
  logic cmd_ok;
  logic [2:0] cmd;
  logic is_mrs;
  logic is_act;
  logic is_pre;
  logic is_rd;
  logic is_wr;
  logic is_bst;
  assign cmd_ok = ~hold & ~cs_n_s; // [R18]
  assign cmd = {ras_n_s, cas_n_s, we_n_s};
  assign is_mrs = cmd_ok && cmd == sdram_pkg::CMD_MRS;
  assign is_act = cmd_ok && cmd == sdram_pkg::CMD_ACT;
  assign is_pre = cmd_ok && cmd == sdram_pkg::CMD_PRE;
  assign is_rd = cmd_ok && cmd == sdram_pkg::CMD_READ;
  assign is_wr = cmd_ok && cmd == sdram_pkg::CMD_WRITE;
  assign is_bst = cmd_ok && cmd == sdram_pkg::CMD_BST;

  // Mode state
  logic [2:0] bl_r; // Burst length code
  logic [2:0] cl_r; // CAS latency code
  logic single_wr_r; // Burst-read, single-write mode

  // Mode set; latencies do not depend on the write mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bl_r <= sdram_pkg::MR_BL_RST;
      cl_r <= sdram_pkg::MR_CL_RST;
      single_wr_r <= sdram_pkg::MR_SINGLE_WR_RST;
    end else if (is_mrs) begin
      bl_r <= addr_s[sdram_pkg::MR_BL_LSB +: 3];
      cl_r <= addr_s[sdram_pkg::MR_CL_LSB +: 3];
      single_wr_r <= addr_s[sdram_pkg::MR_SINGLE_WR_BIT]; // [R11]
    end
  end

  // Wrap mask of the column counter for the programmed length
  logic [7:0] len_mask;
  logic full_page;
  always_comb begin
    unique case (bl_r)
      sdram_pkg::BL_1: len_mask = 8'h00;
      sdram_pkg::BL_2: len_mask = 8'h01;
      sdram_pkg::BL_4: len_mask = 8'h03;
      sdram_pkg::BL_8: len_mask = 8'h07;
      // Full page and reserved codes run the whole 256 columns
      default: len_mask = 8'hFF;
    endcase
  end
  assign full_page = bl_r == sdram_pkg::BL_FULL;

  // Bank state: active flags and open rows
  logic [1:0] bank_act_r;
  logic [10:0] open_row_r [0:1];

  // Activate opens a row; precharge closes one bank or both
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bank_act_r <= 2'h0;
      open_row_r[0] <= 11'h000;
      open_row_r[1] <= 11'h000;
    end else if (is_act) begin
      // Timing limits are the controller's to respect
      bank_act_r[addr_s[sdram_pkg::BANK_SELECT_BIT]] <= 1'b1;
      open_row_r[addr_s[sdram_pkg::BANK_SELECT_BIT]] <= addr_s[10:0];
    end else if (is_pre) begin
      if (addr_s[sdram_pkg::ALL_BANKS_BIT]) begin
        bank_act_r <= 2'h0; // [R21]
      end else begin
        bank_act_r[addr_s[sdram_pkg::BANK_SELECT_BIT]] <= 1'b0; // [R21]
      end
    end
  end

  // Next column inside the wrap block; 8-bit sum wraps naturally
  function automatic logic [7:0] next_col(input logic [7:0] start,
                                          input logic [7:0] idx,
                                          input logic [7:0] lmask);
    logic [7:0] sum;
    sum = start + idx;
    next_col = (start & ~lmask) | (sum & lmask);
  endfunction

  // Burst engine state
  sdram_pkg::burst_state_e state_r;
  logic bank_r; // Bank of the running burst
  logic [7:0] start_r; // Start column of the burst
  logic [7:0] cnt_r; // Beats already issued
  logic [7:0] col_r; // Column of the next beat

  // Burst stop or precharge hitting the burst bank ends it
  logic pre_hit;
  logic stop;
  logic beat;
  logic new_cmd;
  logic burst_end;
  assign pre_hit = is_pre && (addr_s[sdram_pkg::ALL_BANKS_BIT] ||
                   addr_s[sdram_pkg::BANK_SELECT_BIT] == bank_r);
  assign stop = is_bst | pre_hit;
  assign new_cmd = is_rd | is_wr;
  // A beat runs even when masked; masks touch buffers only
  assign beat = ~hold & ~new_cmd & ~stop &
                (state_r != sdram_pkg::BS_IDLE); // [R8]
  assign burst_end = ~full_page && cnt_r == len_mask;

  // Burst sequencing; a new read or write overrides a running burst
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= sdram_pkg::BS_IDLE;
      bank_r <= 1'b0;
      start_r <= 8'h00;
      cnt_r <= 8'h00;
      col_r <= 8'h00;
    end else if (new_cmd) begin
      // Counter reloads from the command column
      bank_r <= addr_s[sdram_pkg::BANK_SELECT_BIT];
      start_r <= addr_s[7:0];
      cnt_r <= 8'h01;
      col_r <= next_col(addr_s[7:0], 8'h01, len_mask); // [R22]
      if (len_mask == 8'h00 || (is_wr && single_wr_r)) begin
        state_r <= sdram_pkg::BS_IDLE; // [R11]
      end else if (is_rd) begin
        state_r <= sdram_pkg::BS_READ;
      end else begin
        state_r <= sdram_pkg::BS_WRITE;
      end
    end else if (stop) begin
      // Write data stops in the stop cycle itself
      state_r <= sdram_pkg::BS_IDLE; // [R4]
    end else if (beat) begin
      cnt_r <= cnt_r + 8'h01;
      col_r <= next_col(start_r, cnt_r + 8'h01, len_mask); // [R1] [R22]
      if (burst_end) begin
        state_r <= sdram_pkg::BS_IDLE;
      end
    end
  end

  // Array access for this cycle
  logic acc_rd;
  logic acc_wr;
  logic acc_bank;
  logic [7:0] acc_col;
  logic [19:0] acc_addr;
  logic we_lo;
  logic we_hi;
  assign acc_rd = is_rd | (beat && state_r == sdram_pkg::BS_READ);
  assign acc_wr = is_wr | (beat && state_r == sdram_pkg::BS_WRITE);
  assign acc_bank = new_cmd ? addr_s[sdram_pkg::BANK_SELECT_BIT] : bank_r;
  assign acc_col = new_cmd ? addr_s[7:0] : col_r;
  assign acc_addr = {acc_bank, open_row_r[acc_bank], acc_col};
  // Write data taken with no latency; each mask drops its own byte
  assign we_lo = acc_wr & ~lm_s; // [R9] [R10]
  assign we_hi = acc_wr & ~um_s; // [R9] [R10]

  // Storage for both banks; no reset, contents are undefined at power up
  logic [15:0] mem_r [0:(1 << sdram_pkg::MEM_AW) - 1];

  // Byte-wise array write
  always_ff @(posedge clk) begin
    if (we_lo) begin
      mem_r[acc_addr][7:0] <= dq_s[7:0];
    end
    if (we_hi) begin
      mem_r[acc_addr][15:8] <= dq_s[15:8];
    end
  end

  // Read latency pipe; lane register adds the last stage
  logic p1_v_r;
  logic p2_v_r;
  logic [15:0] p1_d_r;
  logic [15:0] p2_d_r;
  logic sel_v;
  logic [15:0] sel_d;

  // Pipe freezes with the rest during suspend
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      p1_v_r <= 1'b0;
      p2_v_r <= 1'b0;
      p1_d_r <= 16'h0000;
      p2_d_r <= 16'h0000;
    end else if (!hold) begin
      p1_v_r <= acc_rd;
      p1_d_r <= mem_r[acc_addr];
      p2_v_r <= p1_v_r;
      p2_d_r <= p1_d_r;
    end
  end

  // Latency choice ignores the write mode bit
  assign sel_v = (cl_r == sdram_pkg::CL_2) ? p1_v_r : p2_v_r; // [R12]
  assign sel_d = (cl_r == sdram_pkg::CL_2) ? p1_d_r : p2_d_r;

  // Lower lane follows the lower mask only
  byte_lane u_lane_lo (
    .clk(clk),
    .sys_rst(sys_rst),
    .hold(hold),
    .mask(lm_s),
    .rd_valid(sel_v),
    .rd_data(sel_d[7:0]),
    .dq_out(dq_out[7:0]),
    .dq_oe_n(dq_oe_n[7:0])
  ); // [R7]

  // Upper lane follows the upper mask only
  byte_lane u_lane_hi (
    .clk(clk),
    .sys_rst(sys_rst),
    .hold(hold),
    .mask(um_s),
    .rd_valid(sel_v),
    .rd_data(sel_d[15:8]),
    .dq_out(dq_out[15:8]),
    .dq_oe_n(dq_oe_n[15:8])
  ); // [R7]

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Full-page column steps by one and wraps in 8 bits
  property p_fp_step;
    (full_page && beat) |=> col_r == 8'(start_r + cnt_r);
  endproperty
  a_fp_step: assert property (p_fp_step) // [R1]
    else $error("full-page column did not step");

  // Burst stop during a write leaves no further write beat
  property p_bst_stop;
    (is_bst && state_r == sdram_pkg::BS_WRITE) |=>
      state_r == sdram_pkg::BS_IDLE;
  endproperty
  a_bst_stop: assert property (p_bst_stop) // [R4]
    else $error("write kept running after burst stop");

  // Lower byte floats two cycles after its mask
  property p_mask_lo;
    (lm_s && !hold) ##1 !hold |=> dq_oe_n[7:0] == 8'hFF;
  endproperty
  a_mask_lo: assert property (p_mask_lo) // [R5]
    else $error("lower byte driven two cycles after mask");

  // Upper byte floats on its own mask, lower may still drive
  property p_mask_hi;
    (um_s && !hold) ##1 !hold |=> dq_oe_n[15:8] == 8'hFF;
  endproperty
  a_mask_hi: assert property (p_mask_hi) // [R7]
    else $error("upper byte driven two cycles after mask");

  // Fully masked beat still advances the counter
  property p_mask_count;
    (beat && lm_s && um_s) |=> cnt_r == 8'($past(cnt_r) + 8'h01);
  endproperty
  a_mask_count: assert property (p_mask_count) // [R8]
    else $error("masked beat stalled the counter");

  // Masked lower byte keeps its old array contents
  property p_mask_wr;
    (acc_wr && lm_s) |=>
      mem_r[$past(acc_addr)][7:0] == $past(mem_r[acc_addr][7:0]);
  endproperty
  a_mask_wr: assert property (p_mask_wr) // [R9]
    else $error("masked lower byte written");

  // Single-write mode writes one word only
  property p_single;
    (is_wr && single_wr_r) |=> state_r == sdram_pkg::BS_IDLE;
  endproperty
  a_single: assert property (p_single) // [R11]
    else $error("write burst ran in single-write mode");

  // Suspend freezes burst and bank state
  property p_suspend;
    hold |=> $stable(col_r) && $stable(cnt_r) && $stable(bank_act_r);
  endproperty
  a_suspend: assert property (p_suspend) // [R17] [R18]
    else $error("state changed while suspended");

  // Precharge with the all-banks bit closes both banks
  property p_pre_all;
    (is_pre && addr_s[sdram_pkg::ALL_BANKS_BIT]) |=> bank_act_r == 2'h0;
  endproperty
  a_pre_all: assert property (p_pre_all) // [R21]
    else $error("precharge-all left a bank open");

  // Scenarios worth seeing
  c_wrap: cover property (full_page && beat && col_r == start_r - 8'h01);
  c_bst: cover property (is_bst && state_r == sdram_pkg::BS_WRITE);
  c_rd_mask: cover property (sel_v && lm_s && !um_s);
  c_suspend: cover property (hold && state_r != sdram_pkg::BS_IDLE);

endmodule

/* File: dv/ctrl_model.sv */
// Controller model: drives command, mask and data pins of the core.
// Assumes the core samples its pins on the rising edge of clk.
`timescale 1ns/1ps
module ctrl_model #(
  parameter int T_RP = 2,
  parameter int T_RCD = 3,
  parameter int T_CKA = 2
) (
  input wire logic clk,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [11:0] addr,
  output logic upper_byte_mask,
  output logic lower_byte_mask,
  output logic [15:0] dq_in
);
  // Pins start deselected (chip select high) with the clock gate open
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n, addr} = {5'h1F, 12'h000};
    {upper_byte_mask, lower_byte_mask, dq_in} = 18'h00000;
  end

  // One command cycle, changed off the sampling edge
  task automatic issue(input logic [2:0] c, input logic [11:0] a,
    input logic [15:0] d, input logic um, input logic lm);
    @(negedge clk);
    {cs_n, ras_n, cas_n, we_n, addr} = {1'b0, c, a};
    {upper_byte_mask, lower_byte_mask, dq_in} = {um, lm, d};
  endtask

  // Command pins set with chip select high; the core must ignore it
  task automatic issue_desel(input logic [2:0] c, input logic [11:0] a,
    input logic [15:0] d);
    @(negedge clk);
    {cs_n, ras_n, cas_n, we_n, addr} = {1'b1, c, a};
    {upper_byte_mask, lower_byte_mask, dq_in} = {2'b00, d};
  endtask

  // Idle cycles; each one issues command code 7 with chip select low
  task automatic nop(input int n);
    repeat (n) issue(3'h7, 12'h000, 16'h0000, 1'b0, 1'b0);
  endtask

  // Close both banks, then open one row after recovery
  task automatic open_row(input logic bank, input logic [10:0] row);
    issue(sdram_pkg::CMD_PRE, 12'h400, 16'h0000, 1'b0, 1'b0);
    nop(T_RP);
    issue(sdram_pkg::CMD_ACT, {bank, row}, 16'h0000, 1'b0, 1'b0);
    nop(T_RCD);
  endtask

  // Suspend kept short so no refresh is missed
  task automatic set_cke(input logic v);
    @(negedge clk);
    cke = v;
    if (v)
      nop(T_CKA);
  endtask
endmodule

/* File: dv/sdram_burst_mask_suspend_test.sv */
// Bench for the SDRAM core: full page, masks, single write, suspend.
// Assumes the controller model in ctrl_model.sv drives all pins.
`timescale 1ns/1ps
module sdram_burst_mask_suspend_test;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cke, cs_n, ras_n, cas_n, we_n;
  logic [11:0] addr;
  logic upper_byte_mask, lower_byte_mask;
  logic [15:0] dq_in, dq_out, dq_oe_n;
  int num_errors = 0;
  int n_compared = 0;
  // Expected row contents, bank 0 row 0
  logic [15:0] exp_mem [256];

  // 125 MHz clock
  always #4 clk = ~clk;

  sdram_bms_core i_dut (.clk(clk), .sys_rst(sys_rst), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr),
    .upper_byte_mask(upper_byte_mask), .lower_byte_mask(lower_byte_mask),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n));

  ctrl_model i_ctrl (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .addr(addr),
    .upper_byte_mask(upper_byte_mask), .lower_byte_mask(lower_byte_mask),
    .dq_in(dq_in));

  // Compare and count; case inequality so X matches only X
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    n_compared++;
    if (got !== want) begin
      num_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic wrap_up();
    if (num_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Drain a burst of up to 8 beats (a full-page burst needs a stop), then load the mode word
  task automatic mode(input logic [11:0] a);
    i_ctrl.nop(10);
    i_ctrl.issue(sdram_pkg::CMD_MRS, a, 16'h0000, 1'b0, 1'b0);
    i_ctrl.nop(4);
  endtask

  // Write burst of n beats, then burst stop with junk data
  task automatic wr(input logic [7:0] col, input int n,
    input logic [7:0] seed, input logic [15:0] um_v,
    input logic [15:0] lm_v, input bit single);
    logic [15:0] d;
    logic [7:0] c;
    logic um, lm;
    for (int i = 0; i <= n; i++) begin
      // High byte flips after 256 beats so the wrapped beat is visible
      d = {seed ^ 8'(i >> 8), 8'(i)};
      c = col + 8'(i);
      um = i < 16 && um_v[i];
      lm = i < 16 && lm_v[i];
      if (i == n)
        i_ctrl.issue(sdram_pkg::CMD_BST, 12'h000, ~d, 1'b0, 1'b0);
      else begin
        i_ctrl.issue(i == 0 ? sdram_pkg::CMD_WRITE : 3'h7, {4'h0, col},
          d, um, lm);
        // Single-write mode keeps only the first word
        if (!single || i == 0) begin
          if (!lm)
            exp_mem[c][7:0] = d[7:0];
          if (!um)
            exp_mem[c][15:8] = d[15:8];
        end
      end
    end
  endtask

  // Read n beats at latency cl; optional command at cycle mi
  task automatic rd(input logic [7:0] col, input int n, input int cl,
    input logic [15:0] um_v, input logic [15:0] lm_v,
    input int mi, input logic [11:0] ma);
    logic [15:0] oe;
    int j, k;
    for (int i = 0; i < n + cl + 2; i++) begin
      // Mask lead is fixed, so it shifts against beats with cl
      j = i - (cl - 2);
      // Beat b shows at iteration b+cl+2: cl includes the lane flop, +2 is the two sync stages
      k = i - cl - 2;
      i_ctrl.issue(i == 0 ? sdram_pkg::CMD_READ :
        (i == mi ? sdram_pkg::CMD_PRE : 3'h7), i == mi ? ma : {4'h0, col},
        16'h0000, j >= 0 && j < 16 && um_v[j], j >= 0 && j < 16 && lm_v[j]);
      if (k >= 0) begin
        oe = {(k < 16 && um_v[k]) ? 8'hFF : 8'h00,
          (k < 16 && lm_v[k]) ? 8'hFF : 8'h00};
        chk(dq_oe_n, oe);
        chk(dq_out | oe, exp_mem[col + 8'(k)] | oe);
      end
    end
  endtask

  // Outputs released after lim cycles and stay released
  task automatic idle_chk(input int lim);
    for (int t = 0; t < lim + 4; t++) begin
      i_ctrl.nop(1);
      if (t >= lim)
        chk(dq_oe_n, 16'hFFFF);
    end
  endtask

  // Full page write wraps after 256 beats; stop beat is dropped
  task automatic s_full_page();
    mode(12'h027);
    i_ctrl.open_row(1'b0, 11'h000);
    wr(8'h10, 257, 8'hA5, 16'h0000, 16'h0000, 1'b0);
    rd(8'h10, 258, 2, 16'h0220, 16'h0038, -1, 12'h000);
    i_ctrl.issue(sdram_pkg::CMD_BST, 12'h000, 16'h0000, 1'b0, 1'b0);
  endtask

  // Masked write beats leave their byte alone, counter moves on
  task automatic s_wr_mask();
    wr(8'h40, 6, 8'h3C, 16'h0014, 16'h0006, 1'b0);
    rd(8'h40, 8, 2, 16'h0000, 16'h0000, -1, 12'h000);
    i_ctrl.issue(sdram_pkg::CMD_BST, 12'h000, 16'h0000, 1'b0, 1'b0);
  endtask

  // Other-bank precharge keeps the burst; all-bank one ends it
  task automatic s_precharge();
    rd(8'h00, 10, 2, 16'h0000, 16'h0000, 3, 12'h800);
    i_ctrl.issue(sdram_pkg::CMD_PRE, 12'h400, 16'h0000, 1'b0, 1'b0);
    idle_chk(6);
    i_ctrl.open_row(1'b0, 11'h000);
  endtask

  // Burst 8, CAS 3, single write: one word stored, reads burst
  task automatic s_single();
    mode(12'h233);
    wr(8'h60, 4, 8'h5A, 16'h0000, 16'h0000, 1'b1);
    rd(8'h60, 8, 3, 16'h0004, 16'h0040, -1, 12'h000);
    idle_chk(0);
  endtask

  // Suspend mid read: write ignored, burst resumes to its end
  task automatic s_suspend();
    logic [15:0] last;
    mode(12'h023);
    last = ~exp_mem[8'h07];
    i_ctrl.issue(sdram_pkg::CMD_READ, 12'h000, 16'h0000, 1'b0, 1'b0);
    i_ctrl.nop(2);
    // Deselected write must neither cut the burst nor touch the array
    i_ctrl.issue_desel(sdram_pkg::CMD_WRITE, 12'h020, 16'hCAFE);
    i_ctrl.nop(3);
    i_ctrl.set_cke(1'b0);
    i_ctrl.issue(sdram_pkg::CMD_WRITE, 12'h020, 16'hBEEF, 1'b0, 1'b0);
    i_ctrl.nop(3);
    i_ctrl.set_cke(1'b1);
    repeat (20) begin
      i_ctrl.nop(1);
      if (dq_oe_n === 16'h0000)
        last = dq_out;
    end
    chk(last, exp_mem[8'h07]);
    rd(8'h20, 1, 2, 16'h0000, 16'h0000, -1, 12'h000);
  endtask

  // Hang guard, well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    wrap_up();
  end

  // Reset for 16 cycles, then the scenarios in turn
  initial begin
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    s_full_page();
    s_wr_mask();
    s_precharge();
    s_single();
    s_suspend();
    wrap_up();
  end
endmodule
